// file: src/sstby_pkg.sv
/*
  sstby_pkg: constants shared by the software standby controller.
  assumes one 25 MHz clock and an AXI4-Lite register port.
*/
package sstby_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SYSCTL  = 8'h00;
  localparam logic [7:0] OFF_DIVCTL  = 8'h04;
  localparam logic [7:0] OFF_IRQEN   = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_REFRESH = 8'h10;
  // system control field positions
  localparam int SYS_SLP_MODE  = 7;
  localparam int SYS_STS_LO    = 4;
  localparam int SYS_NMI_EDGE  = 3;
  localparam int SYS_OUT_EN    = 1;
  // reset values
  localparam logic [7:0] SYSCTL_RST  = 8'h00;
  localparam logic [1:0] DIV_RST     = 2'h0;
  localparam logic [2:0] IRQEN_RST   = 3'h0;
  localparam logic [7:0] REFCS_RST   = 8'h00;
  // refresh control/status bits cleared on entry
  localparam logic [7:0] REFCS_ENTRY_MASK = 8'hc0;
  // settling waits in states
  localparam logic [17:0] WAIT_8192   = 18'h02000;
  localparam logic [17:0] WAIT_16384  = 18'h04000;
  localparam logic [17:0] WAIT_32768  = 18'h08000;
  localparam logic [17:0] WAIT_65536  = 18'h10000;
  localparam logic [17:0] WAIT_131072 = 18'h20000;
  localparam logic [18:0] WAIT_262144 = 19'h40000;
  localparam logic [17:0] WAIT_1024   = 18'h00400;
  localparam logic [2:0]  STS_ILLEGAL = 3'h7;
  localparam logic [1:0]  AXI_OKAY    = 2'h0;
  localparam logic [1:0]  AXI_SLVERR  = 2'h2;
  typedef enum logic [3:0] {
    SS_RUN    = 4'b0001,
    SS_HALTED = 4'b0010,
    SS_SETTLE = 4'b0100,
    SS_RESET  = 4'b1000
  } sstby_state_e;
endpackage

// file: src/sstby_settle.sv
/*
  sstby_settle: settling counter clocked by a state enable.
  assumes start is a one-cycle pulse; done pulses at the end of the wait.
*/
module sstby_settle (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        state_en,
  input  wire logic [18:0] length,
  output logic             done
);
  logic [18:0] remain;
  logic        busy;

  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      remain <= 19'h00000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      remain <= length;
      busy   <= 1'b1;
      done   <= 1'b0;
    end else if (busy && state_en) begin
      remain <= remain - 19'h00001;
      if (remain == 19'h00001) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule

// file: src/sstby_ctrl.sv
/*
  sstby_ctrl: software standby sequencer with AXI4-Lite registers.
  assumes the cpu raises sleep_exec for one cycle at the sleep instruction,
  pins are synchronous to aclk, irq pins are active low.
*/
// Operation
// R1 - sleep with standby select set enters software standby
// R2 - standby halts cpu, clock and modules, resets dma and modules
// R3 - cpu registers, ram, ports and dram settings are retained
// R4 - entry clears refresh counter and refresh status bits 7 and 6
// R5 - software clears timer enable before standby select, and reverse
// R6 - software clears bus release enable before entering standby
// R7 - only nmi, irq0-2, reset pin low or standby pin low wake
// R8 - interrupt wake counts settling time then resumes with interrupt handling
// R9 - disabled or cpu-masked irq0-2 do not wake
// R10 - reset pin low restarts clock at once; reset handling at release
// R11 - external logic holds reset low until oscillator stable
// R12 - standby pin low goes directly to hardware standby
// R13 - settling code picks 8192..262144 or 1024 states; 111 illegal
// R14 - crystal use needs a settling wait of at least 7 ms
// R15 - external clock allows any legal settling and divider setting
// R16 - nmi edge select 0 falling, 1 rising edge
// R17 - settling states are divided clock states, doubling per divider step
// R18 - standby outputs float when enable 0, else address held, controls high
module sstby_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_exec,
  input  wire logic        nmi_pin,
  input  wire logic [2:0]  irq_pin_n,
  input  wire logic [2:0]  irq_cpu_mask,
  input  wire logic        reset_pin_n,
  input  wire logic        hw_standby_pin_n,
  input  wire logic        refresh_tick,
  output logic             clock_run,
  output logic             cpu_halt,
  output logic             module_reset,
  output logic             irq_exception,
  output logic             reset_exception,
  output logic             hw_standby_req,
  output logic             bus_out_en,
  output logic             addr_hold,
  output logic             ctrl_force_high,
  output logic [7:0]       refresh_counter
);
  sstby_pkg::sstby_state_e state;
  logic [7:0]  system_control_reg;
  logic [1:0]  divider_control_reg;
  logic [2:0]  irq_enable;
  logic [7:0]  refresh_control_status;
  logic        nmi_prev;
  logic        nmi_edge;
  logic        irq_wake;
  logic        enter;
  logic        settle_start;
  logic        settle_done;
  logic [2:0]  settling_select;
  logic [18:0] wait_len;
  logic [2:0]  div_cnt;
  logic        state_en;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  assign settling_select = system_control_reg[sstby_pkg::SYS_STS_LO +: 3];

  //////////////////////////////////////////////////////////////////////////
  // wake detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev <= 1'b0;
    end else begin
      nmi_prev <= nmi_pin;
    end
  end

  always_comb begin
    if (system_control_reg[sstby_pkg::SYS_NMI_EDGE]) begin
      nmi_edge = nmi_pin && !nmi_prev; // R16
    end else begin
      nmi_edge = !nmi_pin && nmi_prev; // R16
    end
  end

  assign irq_wake = |(~irq_pin_n & irq_enable & ~irq_cpu_mask); // R9
  assign enter = (state == sstby_pkg::SS_RUN) && sleep_exec
               && system_control_reg[sstby_pkg::SYS_SLP_MODE]; // R1

  //////////////////////////////////////////////////////////////////////////
  // settling length and divided state enable
  always_comb begin
    case (settling_select) // R13
      3'h0:    wait_len = {1'b0, sstby_pkg::WAIT_8192};
      3'h1:    wait_len = {1'b0, sstby_pkg::WAIT_16384};
      3'h2:    wait_len = {1'b0, sstby_pkg::WAIT_32768};
      3'h3:    wait_len = {1'b0, sstby_pkg::WAIT_65536};
      3'h4:    wait_len = {1'b0, sstby_pkg::WAIT_131072};
      3'h5:    wait_len = sstby_pkg::WAIT_262144;
      3'h6:    wait_len = {1'b0, sstby_pkg::WAIT_1024};
      default: wait_len = sstby_pkg::WAIT_262144;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || settle_start) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  always_comb begin
    case (divider_control_reg) // R17
      2'h0:    state_en = 1'b1;
      2'h1:    state_en = div_cnt[0];
      2'h2:    state_en = &div_cnt[1:0];
      default: state_en = &div_cnt;
    endcase
  end

  assign settle_start = (state == sstby_pkg::SS_HALTED) && reset_pin_n && hw_standby_pin_n
                      && (nmi_edge || irq_wake);

  sstby_settle u_settle (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (settle_start),
    .abort    (!reset_pin_n || !hw_standby_pin_n),
    .state_en (state_en),
    .length   (wait_len),
    .done     (settle_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= sstby_pkg::SS_RUN;
    end else begin
      case (state)
        sstby_pkg::SS_RUN: begin
          if (enter) begin
            state <= sstby_pkg::SS_HALTED;
          end
        end
        sstby_pkg::SS_HALTED: begin
          if (!hw_standby_pin_n) begin
            state <= sstby_pkg::SS_RUN; // R12
          end else if (!reset_pin_n) begin
            state <= sstby_pkg::SS_RESET; // R10
          end else if (settle_start) begin
            state <= sstby_pkg::SS_SETTLE; // R7 R8
          end
        end
        sstby_pkg::SS_SETTLE: begin
          if (!hw_standby_pin_n) begin
            state <= sstby_pkg::SS_RUN; // R12
          end else if (!reset_pin_n) begin
            state <= sstby_pkg::SS_RESET; // R10
          end else if (settle_done) begin
            state <= sstby_pkg::SS_RUN; // R8
          end
        end
        sstby_pkg::SS_RESET: begin
          if (!hw_standby_pin_n || reset_pin_n) begin
            state <= sstby_pkg::SS_RUN; // R10 R11
          end
        end
        default: state <= sstby_pkg::SS_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_exception   <= 1'b0;
      reset_exception <= 1'b0;
      hw_standby_req  <= 1'b0;
    end else begin
      irq_exception   <= (state == sstby_pkg::SS_SETTLE) && settle_done
                       && reset_pin_n && hw_standby_pin_n; // R8
      reset_exception <= (state == sstby_pkg::SS_RESET) && reset_pin_n
                       && hw_standby_pin_n; // R10
      hw_standby_req  <= (state != sstby_pkg::SS_RUN) && !hw_standby_pin_n; // R12
    end
  end

  // clock stays stopped while settling; runs again at once under reset
  assign clock_run    = (state == sstby_pkg::SS_RUN) || (state == sstby_pkg::SS_RESET); // R2 R10
  assign cpu_halt     = (state != sstby_pkg::SS_RUN); // R2 R3
  assign module_reset = (state == sstby_pkg::SS_HALTED) || (state == sstby_pkg::SS_SETTLE); // R2
  assign bus_out_en      = !cpu_halt || system_control_reg[sstby_pkg::SYS_OUT_EN]; // R18
  assign addr_hold       = cpu_halt && system_control_reg[sstby_pkg::SYS_OUT_EN]; // R18
  assign ctrl_force_high = addr_hold; // R18

  //////////////////////////////////////////////////////////////////////////
  // refresh counter, cleared on entry, held otherwise in standby
  always_ff @(posedge aclk) begin
    if (!aresetn || enter) begin
      refresh_counter <= 8'h00; // R4
    end else if (refresh_tick && !cpu_halt) begin
      refresh_counter <= refresh_counter + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sstby_pkg::AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr[7:2])
        sstby_pkg::OFF_SYSCTL[7:2], sstby_pkg::OFF_DIVCTL[7:2],
        sstby_pkg::OFF_IRQEN[7:2], sstby_pkg::OFF_STATUS[7:2],
        sstby_pkg::OFF_REFRESH[7:2]: s_axi_bresp <= sstby_pkg::AXI_OKAY;
        default: s_axi_bresp <= sstby_pkg::AXI_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_control_reg  <= sstby_pkg::SYSCTL_RST;
      divider_control_reg <= sstby_pkg::DIV_RST;
      irq_enable          <= sstby_pkg::IRQEN_RST;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        sstby_pkg::OFF_SYSCTL: begin
          system_control_reg <= w_data[7:0] & 8'hfa;
          if (w_data[6:4] == sstby_pkg::STS_ILLEGAL) begin
            system_control_reg[6:4] <= system_control_reg[6:4]; // R13
          end
        end
        sstby_pkg::OFF_DIVCTL: divider_control_reg <= w_data[1:0];
        sstby_pkg::OFF_IRQEN:  irq_enable <= w_data[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_control_status <= sstby_pkg::REFCS_RST;
    end else if (enter) begin
      refresh_control_status <= refresh_control_status & ~sstby_pkg::REFCS_ENTRY_MASK; // R4
    end else if (do_write && w_strb[0] && aw_addr == sstby_pkg::OFF_REFRESH) begin
      refresh_control_status <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= sstby_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= sstby_pkg::AXI_OKAY;
      case (s_axi_araddr)
        sstby_pkg::OFF_SYSCTL:  s_axi_rdata <= {24'h000000, system_control_reg};
        sstby_pkg::OFF_DIVCTL:  s_axi_rdata <= {30'h00000000, divider_control_reg};
        sstby_pkg::OFF_IRQEN:   s_axi_rdata <= {29'h00000000, irq_enable};
        sstby_pkg::OFF_STATUS:  s_axi_rdata <= {16'h0000, refresh_counter, 4'h0, state};
        sstby_pkg::OFF_REFRESH: s_axi_rdata <= {24'h000000, refresh_control_status};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= sstby_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: sim/sstby_ctrl_properties.sv
/*
  sstby_ctrl_properties: port checker for the standby sequencer.
  assumes aw and w of one write are taken at the same edge.
*/
module sstby_ctrl_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        sleep_exec,
  input wire logic        reset_pin_n,
  input wire logic        hw_standby_pin_n,
  input wire logic        clock_run,
  input wire logic        cpu_halt,
  input wire logic        module_reset,
  input wire logic        irq_exception,
  input wire logic        hw_standby_req,
  input wire logic        bus_out_en,
  input wire logic        addr_hold,
  input wire logic        ctrl_force_high,
  input wire logic [7:0]  refresh_counter
);
  logic        sel_sh;
  logic        soe;
  logic [11:0] halt_cnt;
  logic        wr_sys;
  assign wr_sys = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                  && s_axi_awaddr == sstby_pkg::OFF_SYSCTL && s_axi_wstrb[0];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // shadow of the system control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_sh <= 1'b0;
      soe    <= 1'b0;
    end else if (wr_sys) begin
      sel_sh <= s_axi_wdata[sstby_pkg::SYS_SLP_MODE];
      soe    <= s_axi_wdata[sstby_pkg::SYS_OUT_EN];
    end
  end
  // cycles spent held since the last sleep
  always_ff @(posedge aclk) begin
    if (!aresetn || sleep_exec) begin
      halt_cnt <= 12'h000;
    end else if (module_reset && halt_cnt != 12'hfff) begin
      halt_cnt <= halt_cnt + 12'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_sleep_enters: assert property (sleep_exec && sel_sh && !cpu_halt |=>
    cpu_halt && module_reset && !clock_run && refresh_counter == 8'h00)
    else $error("sleep with standby select did not enter standby");
  a_sleep_ignored: assert property (sleep_exec && !sel_sh && !cpu_halt |=> !cpu_halt)
    else $error("sleep without standby select halted the cpu");
  a_held_halted: assert property (module_reset |-> cpu_halt && !clock_run)
    else $error("modules held in reset while clock runs");
  a_reset_wake: assert property (module_reset && !reset_pin_n && hw_standby_pin_n |=>
    clock_run && !module_reset)
    else $error("reset pin low did not restart the clock");
  a_settle_wait: assert property ($rose(irq_exception) |-> halt_cnt >= 12'd1024)
    else $error("interrupt wake came before the shortest settling wait");
  a_wake_running: assert property (irq_exception |-> clock_run && !cpu_halt)
    else $error("interrupt handling started without the clock");
  a_bus_standby: assert property (cpu_halt && !clock_run |->
    bus_out_en == soe && addr_hold == soe && ctrl_force_high == soe)
    else $error("bus outputs wrong in standby");
  a_hw_standby: assert property (module_reset && reset_pin_n && !hw_standby_pin_n |=>
    hw_standby_req)
    else $error("standby pin did not request hardware standby");
endmodule

bind sstby_ctrl sstby_ctrl_properties sstby_ctrl_properties_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .sleep_exec, .reset_pin_n,
  .hw_standby_pin_n, .clock_run, .cpu_halt, .module_reset, .irq_exception,
  .hw_standby_req, .bus_out_en, .addr_hold, .ctrl_force_high, .refresh_counter
);

// file: sim/sstby_pins.sv
/*
  sstby_pins: cpu and external pin model around the standby sequencer.
  assumes the bench calls its tasks; pins change just after a rising edge.
*/
module sstby_pins (
  input  wire logic aclk,
  output logic       sleep_exec,
  output logic       nmi_pin,
  output logic [2:0] irq_pin_n,
  output logic [2:0] irq_cpu_mask,
  output logic       reset_pin_n,
  output logic       hw_standby_pin_n,
  output logic       refresh_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick_div = 2'h0;
  initial begin
    sleep_exec = 1'b0;
    set_now(1'b0, 3'h7, 3'h0, 1'b1, 1'b1);
  end
  always @(posedge aclk) tick_div <= tick_div + 2'h1;
  assign refresh_tick = (tick_div == 2'h0);
  task automatic set_now(input logic nmi, input logic [2:0] irq_n, input logic [2:0] mask,
                         input logic rst_n, input logic hw_n);
    nmi_pin          <= nmi;
    irq_pin_n        <= irq_n;
    irq_cpu_mask     <= mask;
    reset_pin_n      <= rst_n;
    hw_standby_pin_n <= hw_n;
  endtask
  task automatic set_pins(input logic nmi, input logic [2:0] irq_n, input logic [2:0] mask,
                          input logic rst_n, input logic hw_n);
    @(posedge aclk);
    set_now(nmi, irq_n, mask, rst_n, hw_n);
  endtask
  // sleep instruction: one-cycle pulse
  task automatic sleep_cmd();
    @(posedge aclk);
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
  endtask
endmodule

// file: sim/sstby_ctrl_tb.sv
/*
  sstby_ctrl_tb: directed test of the standby sequencer through its registers.
  assumes sstby_pins stands for the cpu and the external pins.
*/
module sstby_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sleep_exec, nmi_pin, reset_pin_n, hw_standby_pin_n;
  logic        refresh_tick, clock_run, cpu_halt, module_reset, irq_exception;
  logic        reset_exception, hw_standby_req, bus_out_en, addr_hold, ctrl_force_high;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, refresh_counter;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  irq_pin_n, irq_cpu_mask;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          failures = 0, check_count = 0, n;

  sstby_ctrl sstby_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sleep_exec, .nmi_pin, .irq_pin_n, .irq_cpu_mask,
    .reset_pin_n, .hw_standby_pin_n, .refresh_tick, .clock_run, .cpu_halt, .module_reset,
    .irq_exception, .reset_exception, .hw_standby_req, .bus_out_en, .addr_hold,
    .ctrl_force_high, .refresh_counter);
  sstby_pins sstby_pins_i (.aclk, .sleep_exec, .nmi_pin, .irq_pin_n, .irq_cpu_mask,
    .reset_pin_n, .hw_standby_pin_n, .refresh_tick);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(exp));
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_for(input logic rst, output int cnt);
    cnt = 0;
    while (!(rst ? reset_exception : irq_exception) && cnt < 5000) begin
      @(negedge aclk);
      cnt++;
    end
  endtask
  task automatic enter_standby();
    sstby_pins_i.sleep_cmd();
    repeat (2) @(negedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim();
  end
  initial begin
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(sstby_pkg::OFF_STATUS, rd, rr);
    check(32'(rd[3:0]), 32'h1);
    axw(sstby_pkg::OFF_SYSCTL, 32'h62, sstby_pkg::AXI_OKAY);
    enter_standby();
    check(32'(cpu_halt), 32'h0);
    axw(sstby_pkg::OFF_SYSCTL, 32'hf2, sstby_pkg::AXI_OKAY);
    axr(sstby_pkg::OFF_SYSCTL, rd, rr);
    check(rd, 32'he2);
    axw(8'h14, 32'h1, sstby_pkg::AXI_SLVERR);
    axr(8'h14, rd, rr);
    check({rd[31:2], rr}, {30'h0, sstby_pkg::AXI_SLVERR});
    axw(sstby_pkg::OFF_REFRESH, 32'hff, sstby_pkg::AXI_OKAY);
    $display("test registers done");
    enter_standby();
    check({28'h0, cpu_halt, clock_run, module_reset, bus_out_en}, 32'hb);
    check({29'h0, addr_hold, ctrl_force_high, hw_standby_req}, 32'h6);
    axr(sstby_pkg::OFF_STATUS, rd, rr);
    check(32'(rd[15:0]), 32'h0002);
    axr(sstby_pkg::OFF_REFRESH, rd, rr);
    check(rd, 32'h3f);
    sstby_pins_i.set_pins(1'b0, 3'h6, 3'h1, 1'b1, 1'b1);
    repeat (20) @(negedge aclk);
    axr(sstby_pkg::OFF_STATUS, rd, rr);
    check(32'(rd[3:0]), 32'h2);
    axw(sstby_pkg::OFF_IRQEN, 32'h1, sstby_pkg::AXI_OKAY);
    repeat (20) @(negedge aclk);
    axr(sstby_pkg::OFF_STATUS, rd, rr);
    check(32'(rd[3:0]), 32'h2);
    sstby_pins_i.set_pins(1'b0, 3'h6, 3'h0, 1'b1, 1'b1);
    wait_for(1'b0, n);
    check(32'(n >= 1024 && n <= 1040), 32'h1);
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b1, 1'b1);
    axr(sstby_pkg::OFF_SYSCTL, rd, rr);
    check(rd, 32'he2);
    $display("test interrupt wake done");
    axw(sstby_pkg::OFF_SYSCTL, 32'he8, sstby_pkg::AXI_OKAY);
    axw(sstby_pkg::OFF_DIVCTL, 32'h1, sstby_pkg::AXI_OKAY);
    enter_standby();
    check({29'h0, bus_out_en, addr_hold, ctrl_force_high}, 32'h0);
    sstby_pins_i.set_pins(1'b0, 3'h7, 3'h0, 1'b1, 1'b1);
    repeat (10) @(negedge aclk);
    axr(sstby_pkg::OFF_STATUS, rd, rr);
    check(32'(rd[3:0]), 32'h2);
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b1, 1'b1);
    wait_for(1'b0, n);
    check(32'(n >= 2048 && n <= 2064), 32'h1);
    $display("test nmi wake done");
    enter_standby();
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b0, 1'b1);
    repeat (3) @(negedge aclk);
    check(32'(clock_run), 32'h1);
    repeat (40) @(posedge aclk);
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b1, 1'b1);
    wait_for(1'b1, n);
    check(32'(n < 10), 32'h1);
    $display("test reset wake done");
    enter_standby();
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b1, 1'b0);
    repeat (2) @(negedge aclk);
    check(32'(hw_standby_req), 32'h1);
    sstby_pins_i.set_pins(1'b1, 3'h7, 3'h0, 1'b1, 1'b1);
    $display("test hardware standby done");
    end_sim();
  end
endmodule
